// File: hw/pfmux_pkg.sv
// constants shared by the pad function multiplexer and its register file
// assumes one 25 MHz clock, Avalon-MM register access, word addressing by 4
//
// Overview of operation
// - a pass-through input keeps reading its pad even when another function owns it.
// - a forced-high input reads one while another function is selected.
// - a forced-low input reads zero while another function is selected.
// - a bidirectional forced-high function reads one while it is not selected.
// - the selected bidirectional function owns the pad's input, output and enable.
// - each pad has a 2-bit drive strength, codes 0..3 about 5/10/20/40 mA, reset code 2.
// - while reset is asserted every pad driver is disabled.
// - after reset each pad selects the first function, whose own enable drives it.
// - the matrix can route any peripheral output signal to any pad.
// - some function inputs reach a pad either by the direct mux or by the matrix.
// - slow ethernet management and status signals are routable through the matrix.
// - a matrix input with no pad assigned and no active direct route takes its fixed default value.
// - each assigned matrix input value comes from its pad select and its invert setting.
// - the function select field holds function number minus one.
package pfmux_pkg;

   // ==========================================================
   // sizes
   localparam int NUM_PADS   = 4;
   localparam int NUM_FUNCS  = 6;
   localparam int NUM_MSIG   = 8;
   localparam int FSEL_W     = 3;
   localparam int MSEL_W     = 3;
   localparam int PADIDX_W   = 2;

   // ==========================================================
   // function kinds, two bits per function
   typedef enum logic [1:0] {
      KIND_PASS, KIND_FORCE_HI, KIND_FORCE_LO, KIND_BIDIR_HI
   } pfmux_kind_type;

   // kind of function f on pad p sits at bits [(p*NUM_FUNCS+f)*2 +: 2]
   localparam logic [47:0] FUNC_KIND = 48'h3c9_e4c_9e4_0c9;

   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0] PAD_CFG_BASE   = 8'h00;
   localparam logic [7:0] MIN_CFG_BASE   = 8'h20;
   localparam logic [7:0] PAD_STATUS_OFS = 8'h40;

   // pad config fields
   localparam int PAD_FSEL_LSB  = 0;
   localparam int PAD_DRV_LSB   = 4;
   localparam int PAD_MOSEL_LSB = 8;
   // matrix input config fields
   localparam int MIN_PAD_LSB   = 0;
   localparam int MIN_ASSIGN    = 2;
   localparam int MIN_INVERT    = 3;

   // ==========================================================
   // reset values and special codes
   localparam logic [FSEL_W-1:0] FSEL_RESET    = 3'h0;
   localparam logic [FSEL_W-1:0] FSEL_MATRIX   = 3'h6;
   localparam logic [1:0]        DRV_RESET     = 2'h2;
   localparam logic [MSEL_W-1:0] MOSEL_RESET   = 3'h0;

   // matrix input defaults when unassigned, one bit per input
   localparam logic [NUM_MSIG-1:0] MIN_DEFAULT = 8'h30;
   // inputs that also have a direct-mux route, from function 1 of pad m%4
   localparam logic [NUM_MSIG-1:0] MIN_DIRECT  = 8'h0f;
   // slow ethernet management and status inputs
   localparam int ETH_MGMT_CLK_IDX  = 4;
   localparam int ETH_MGMT_DATA_IDX = 5;
   localparam int ETH_CARRIER_IDX   = 6;
   localparam int ETH_COLLIDE_IDX   = 7;

endpackage

// File: hw/pfmux_top.sv
// pad function multiplexer with signal matrix and avalon register file
// assumes pad and peripheral signals are synchronous to clk
//
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pfmux_top
   import pfmux_pkg::*;
(
   input  wire logic                                  clk,
   input  wire logic                                  resetn,
   input  wire logic [7:0]                            avsAddress,
   input  wire logic                                  avsRead,
   input  wire logic                                  avsWrite,
   input  wire logic [31:0]                           avsWritedata,
   input  wire logic [3:0]                            avsByteenable,
   output logic      [31:0]                           avsReaddata,
   output logic                                       avsWaitrequest,
   input  wire logic [pfmux_pkg::NUM_PADS-1:0]        padIn,
   output logic      [pfmux_pkg::NUM_PADS-1:0]        padOut,
   output logic      [pfmux_pkg::NUM_PADS-1:0]        padOe,
   output logic      [2*pfmux_pkg::NUM_PADS-1:0]      padDrive,
   input  wire logic [pfmux_pkg::NUM_PADS*pfmux_pkg::NUM_FUNCS-1:0] funcOut,
   input  wire logic [pfmux_pkg::NUM_PADS*pfmux_pkg::NUM_FUNCS-1:0] funcOe,
   output logic      [pfmux_pkg::NUM_PADS*pfmux_pkg::NUM_FUNCS-1:0] funcIn,
   input  wire logic [pfmux_pkg::NUM_MSIG-1:0]        matrixOut,
   input  wire logic [pfmux_pkg::NUM_MSIG-1:0]        matrixOe,
   output logic      [pfmux_pkg::NUM_MSIG-1:0]        matrixIn
);
   import pfmux_pkg::*;

   // ==========================================================
   // helpers

   // input seen by a function, from its kind and selection state
   function automatic logic kindInput(input logic [1:0] kind,
                                      input logic       selected,
                                      input logic       pin);
      logic v;
      v = pin;
      if (!selected) begin
         unique case (pfmux_kind_type'(kind))
            KIND_PASS:     v = pin;
            KIND_FORCE_HI: v = 1'b1;
            KIND_FORCE_LO: v = 1'b0;
            KIND_BIDIR_HI: v = 1'b1;
         endcase
      end
      return v;
   endfunction

   // ==========================================================
   // register state
   logic [FSEL_W-1:0] fsel_reg  [NUM_PADS];
   logic [1:0]        drv_reg   [NUM_PADS];
   logic [MSEL_W-1:0] mosel_reg [NUM_PADS];
   logic [3:0]        mcfg_reg  [NUM_MSIG];
   logic              waitReq_reg;
   logic [31:0]       rdata_reg;

   // ==========================================================
   // bus decode; one wait cycle, then the access completes
   wire       busReq    = avsRead | avsWrite;
   wire       busDone   = busReq & ~waitReq_reg;
   wire       isPadCfg  = avsAddress[7:4] == PAD_CFG_BASE[7:4];
   wire       isMinCfg  = avsAddress[7:5] == MIN_CFG_BASE[7:5];
   wire       isStatus  = avsAddress == PAD_STATUS_OFS;
   wire [1:0] padIdx    = avsAddress[3:2];
   wire [2:0] minIdx    = avsAddress[4:2];
   wire       wrPad     = busDone & avsWrite & isPadCfg & avsByteenable[0];
   wire       wrPadHi   = busDone & avsWrite & isPadCfg & avsByteenable[1];
   wire       wrMin     = busDone & avsWrite & isMinCfg & avsByteenable[0];

   // read data for the current address; unmapped reads as zero
   logic [31:0] rdMux;
   assign rdMux = isPadCfg ?
                  {21'h0, mosel_reg[padIdx], 2'h0, drv_reg[padIdx],
                   1'b0, fsel_reg[padIdx]} :
                  isMinCfg ? {28'h0, mcfg_reg[minIdx]} :
                  isStatus ? {24'h0, padOe, padIn} : 32'h0;

   // waitrequest idles high and drops for the completing cycle only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         waitReq_reg <= 1'b1;
         rdata_reg   <= 32'h0;
      end else begin
         waitReq_reg <= ~(busReq & waitReq_reg);
         if (busReq & waitReq_reg & avsRead) begin
            rdata_reg <= rdMux;
         end
      end
   end
   assign avsWaitrequest = waitReq_reg;
   assign avsReaddata    = rdata_reg;

   // pad configuration; reset picks function 1 and drive code 2
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < NUM_PADS; p++) begin
            fsel_reg[p]  <= FSEL_RESET;
            drv_reg[p]   <= DRV_RESET;
            mosel_reg[p] <= MOSEL_RESET;
         end
      end else begin
         if (wrPad) begin
            fsel_reg[padIdx] <= avsWritedata[PAD_FSEL_LSB +: FSEL_W];
            drv_reg[padIdx]  <= avsWritedata[PAD_DRV_LSB +: 2];
         end
         if (wrPadHi) begin
            mosel_reg[padIdx] <= avsWritedata[PAD_MOSEL_LSB +: MSEL_W];
         end
      end
   end

   // matrix input configuration, all unassigned after reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int m = 0; m < NUM_MSIG; m++) begin
            mcfg_reg[m] <= 4'h0;
         end
      end else if (wrMin) begin
         mcfg_reg[minIdx] <= avsWritedata[3:0];
      end
   end

   // ==========================================================
   // pad output side
   logic [NUM_PADS-1:0]          outNext;
   logic [NUM_PADS-1:0]          oeNext;
   logic [2*NUM_PADS-1:0]        drvNext;
   logic [NUM_PADS*NUM_FUNCS-1:0] inNext;

   // only the selected source reaches the pad; codes 7 and up float it
   generate
      for (genvar p = 0; p < NUM_PADS; p++) begin : g_pad
         wire [NUM_FUNCS-1:0] fo = funcOut[p*NUM_FUNCS +: NUM_FUNCS];
         wire [NUM_FUNCS-1:0] fe = funcOe[p*NUM_FUNCS +: NUM_FUNCS];
         wire isDirect = fsel_reg[p] < FSEL_W'(NUM_FUNCS);
         wire isMatrix = fsel_reg[p] == FSEL_MATRIX;
         assign outNext[p] = isDirect ? fo[fsel_reg[p]] :
                             isMatrix ? matrixOut[mosel_reg[p]] :
                             1'b0;
         assign oeNext[p]  = isDirect ? fe[fsel_reg[p]] :
                             isMatrix ? matrixOe[mosel_reg[p]] :
                             1'b0;
         assign drvNext[2*p +: 2] = drv_reg[p];
         for (genvar f = 0; f < NUM_FUNCS; f++) begin : g_fn
            assign inNext[p*NUM_FUNCS+f] =
               kindInput(FUNC_KIND[(p*NUM_FUNCS+f)*2 +: 2],
                         fsel_reg[p] == FSEL_W'(f), padIn[p]);
         end
      end
   endgenerate

   // ==========================================================
   // matrix input side
   logic [NUM_MSIG-1:0] minNext;

   // assigned pad wins, else the direct route, else the fixed default
   generate
      for (genvar m = 0; m < NUM_MSIG; m++) begin : g_min
         localparam int DPAD = m % NUM_PADS;
         wire assigned  = mcfg_reg[m][MIN_ASSIGN];
         wire [PADIDX_W-1:0] src = mcfg_reg[m][MIN_PAD_LSB +: PADIDX_W];
         wire viaDirect = MIN_DIRECT[m] && fsel_reg[DPAD] == FSEL_RESET;
         wire raw = assigned  ? padIn[src] :
                    viaDirect ? padIn[DPAD] :
                    MIN_DEFAULT[m];
         assign minNext[m] = raw ^ (assigned & mcfg_reg[m][MIN_INVERT]);
      end
   endgenerate

   // every output leaves a flop; reset holds all drivers off
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         padOut   <= '0;
         padOe    <= '0;
         padDrive <= {NUM_PADS{DRV_RESET}};
         funcIn   <= '0;
         matrixIn <= MIN_DEFAULT;
      end else begin
         padOut   <= outNext;
         padOe    <= oeNext;
         padDrive <= drvNext;
         funcIn   <= inNext;
         matrixIn <= minNext;
      end
   end

   // ==========================================================
   // checks
   sequence s_resetRelease;
      $rose(resetn);
   endsequence

   chk_reset_oe_off: assert property (@(posedge clk)
      s_resetRelease |-> padOe == '0)
      else $error("pad driver enabled at reset release");

   chk_reset_fsel_one: assert property (@(posedge clk)
      s_resetRelease |-> fsel_reg[0] == FSEL_RESET && drv_reg[0] == DRV_RESET)
      else $error("pad 0 not on function 1 after reset");

   chk_select_drives_pad: assert property (@(posedge clk)
      disable iff (!resetn)
      fsel_reg[1] == 3'h2 ##1 fsel_reg[1] == 3'h2
      |-> padOut[1] == $past(funcOut[1*NUM_FUNCS+2])
          && padOe[1] == $past(funcOe[1*NUM_FUNCS+2]))
      else $error("pad 1 not following function 3");

   chk_unselected_ignored: assert property (@(posedge clk)
      disable iff (!resetn)
      fsel_reg[0] > FSEL_MATRIX |=> padOe[0] == 1'b0)
      else $error("pad 0 driven with no source selected");

   // pad 0: function 1 forced high, 2 forced low, 3 pass, 4 bidirectional
   chk_forced_high_in: assert property (@(posedge clk)
      disable iff (!resetn)
      FUNC_KIND[1:0] == KIND_FORCE_HI && fsel_reg[0] != 3'h0
      |=> funcIn[0] == 1'b1)
      else $error("forced-high input not one when unselected");

   chk_pass_through_in: assert property (@(posedge clk)
      disable iff (!resetn)
      FUNC_KIND[5:4] == KIND_PASS |=> funcIn[2] == $past(padIn[0]))
      else $error("pass-through input lost its pad");

   // forced-low input reads zero while another function owns pad 0
   chk_forced_low_in: assert property (@(posedge clk)
      disable iff (!resetn)
      fsel_reg[0] != 3'h1 |=> funcIn[1] == 1'b0)
      else $error("forced-low input not zero when unselected");

   // bidirectional forced-high input reads one when not selected
   chk_bidir_high_in: assert property (@(posedge clk)
      disable iff (!resetn)
      fsel_reg[0] != 3'h3 |=> funcIn[3] == 1'b1)
      else $error("bidirectional input not one when unselected");

   // the selected bidirectional function sees the pin itself
   chk_selected_reads_pin: assert property (@(posedge clk)
      disable iff (!resetn)
      fsel_reg[0] == 3'h3 |=> funcIn[3] == $past(padIn[0]))
      else $error("selected function does not read its pad");

   // a matrix pad follows the chosen matrix signal and its enable
   chk_matrix_route_out: assert property (@(posedge clk)
      disable iff (!resetn)
      fsel_reg[2] == FSEL_MATRIX
      |=> padOut[2] == $past(matrixOut[mosel_reg[2]])
          && padOe[2] == $past(matrixOe[mosel_reg[2]]))
      else $error("pad 2 not following its matrix signal");

   // unassigned input 0 falls back to the direct route of pad 0
   chk_direct_route_in: assert property (@(posedge clk)
      disable iff (!resetn)
      !mcfg_reg[0][MIN_ASSIGN] && fsel_reg[0] == FSEL_RESET
      |=> matrixIn[0] == $past(padIn[0]))
      else $error("matrix input 0 not fed by its direct route");

   // the management clock slot takes any pad through the matrix
   chk_eth_mgmt_route: assert property (@(posedge clk)
      disable iff (!resetn)
      mcfg_reg[ETH_MGMT_CLK_IDX][MIN_ASSIGN]
      |=> matrixIn[ETH_MGMT_CLK_IDX] ==
          $past(padIn[mcfg_reg[ETH_MGMT_CLK_IDX][1:0]]
                ^ mcfg_reg[ETH_MGMT_CLK_IDX][MIN_INVERT]))
      else $error("management clock input not routed from its pad");

   // a written select code lands as the function number minus one
   chk_fsel_write: assert property (@(posedge clk)
      disable iff (!resetn)
      wrPad |=> fsel_reg[$past(padIdx)]
                == $past(avsWritedata[PAD_FSEL_LSB +: FSEL_W]))
      else $error("function select not stored as written");

   // drivers stay off for as long as reset is held
   chk_oe_in_reset: assert property (@(posedge clk)
      !resetn |-> padOe == '0)
      else $error("pad driver enabled during reset");

   // drive strength leaves reset at code 2 on every pad
   chk_drive_reset: assert property (@(posedge clk)
      s_resetRelease |-> padDrive == {NUM_PADS{DRV_RESET}})
      else $error("drive code not 2 at reset release");

   // matrix inputs leave reset at their fixed defaults
   chk_matrix_in_reset: assert property (@(posedge clk)
      s_resetRelease |-> matrixIn == MIN_DEFAULT)
      else $error("matrix inputs not at default after reset");

   // a code above the matrix code floats the pad entirely
   chk_no_source_float: assert property (@(posedge clk)
      disable iff (!resetn)
      fsel_reg[3] > FSEL_MATRIX |=> padOut[3] == 1'b0 && padOe[3] == 1'b0)
      else $error("pad 3 driven with no source selected");

   // waitrequest is low for a single cycle per access
   chk_wait_one_cycle: assert property (@(posedge clk)
      disable iff (!resetn)
      !avsWaitrequest |=> avsWaitrequest)
      else $error("waitrequest low for more than one cycle");

   // read data is captured at the end of the wait cycle, on the edge that drops waitrequest
   chk_read_data: assert property (@(posedge clk)
      disable iff (!resetn)
      busReq && waitReq_reg && avsRead |=> avsReaddata == $past(rdMux))
      else $error("read data not taken from the addressed register");

   chk_drive_code: assert property (@(posedge clk)
      disable iff (!resetn)
      wrPad ##1 1'b1 |=> padDrive[2*$past(padIdx,2) +: 2]
                         == $past(avsWritedata[PAD_DRV_LSB +: 2], 2))
      else $error("drive code not applied two cycles after write");

   chk_matrix_default: assert property (@(posedge clk)
      disable iff (!resetn)
      !mcfg_reg[6][MIN_ASSIGN] && !MIN_DIRECT[6]
      |=> matrixIn[6] == MIN_DEFAULT[6])
      else $error("unassigned matrix input left its default");

   chk_matrix_invert: assert property (@(posedge clk)
      disable iff (!resetn)
      mcfg_reg[4][MIN_ASSIGN]
      |=> matrixIn[4] == $past(padIn[mcfg_reg[4][1:0]]
                               ^ mcfg_reg[4][MIN_INVERT]))
      else $error("matrix input 4 not pad xor invert");

   chk_bus_answer: assert property (@(posedge clk)
      disable iff (!resetn)
      busReq && waitReq_reg |=> !avsWaitrequest)
      else $error("bus request not answered after one wait cycle");

endmodule
`default_nettype wire

// File: testbench/pfmux_far_model.sv
// far-side model: peripheral function drivers and the package pads
// assumes the bench sets peripheral values just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module pfmux_far_model
   import pfmux_pkg::*;
(
   input  wire logic                            clk,
   input  wire logic [NUM_PADS*NUM_FUNCS-1:0]   setOut,
   input  wire logic [NUM_PADS*NUM_FUNCS-1:0]   setOe,
   input  wire logic [NUM_MSIG-1:0]             setMOut,
   input  wire logic [NUM_MSIG-1:0]             setMOe,
   input  wire logic [NUM_PADS-1:0]             extLevel,
   input  wire logic [NUM_PADS-1:0]             padOut,
   input  wire logic [NUM_PADS-1:0]             padOe,
   output logic      [NUM_PADS-1:0]             padIn,
   output logic      [NUM_PADS*NUM_FUNCS-1:0]   funcOut,
   output logic      [NUM_PADS*NUM_FUNCS-1:0]   funcOe,
   output logic      [NUM_MSIG-1:0]             matrixOut,
   output logic      [NUM_MSIG-1:0]             matrixOe
);
   // ==========================================================
   // peripherals launch from their own flops, one cycle behind the bench
   always_ff @(posedge clk) begin
      funcOut <= setOut;
      funcOe <= setOe;
      matrixOut <= setMOut;
      matrixOe <= setMOe;
   end
   // a driven pad reads back its own level, an idle one the board level
   assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule
`default_nettype wire

// File: testbench/test_pad_function_mux.sv
// self-checking bench for the pad function multiplexer
// assumes the far-side model feeds peripherals and pads
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_pad_function_mux;
   import pfmux_pkg::*;
   logic clk = 0, resetn, avsRead = 0, avsWrite = 0, avsWaitrequest;
   logic [7:0] avsAddress = 0, padDrive, setMOut = 0, setMOe = 0;
   logic [7:0] matrixOut, matrixOe, matrixIn;
   logic [31:0] avsWritedata = 0, avsReaddata, q;
   logic [3:0] avsByteenable = 4'hf, padIn, padOut, padOe, extLevel = 0;
   logic [23:0] funcOut, funcOe, funcIn, setOut = '1, setOe = '1;
   int errors = 0, n_tests = 0, cycles = 0;
   pfmux_top uut (.clk(clk), .resetn(resetn), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
      .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .padIn(padIn), .padOut(padOut),
      .padOe(padOe), .padDrive(padDrive), .funcOut(funcOut), .funcOe(funcOe),
      .funcIn(funcIn), .matrixOut(matrixOut), .matrixOe(matrixOe),
      .matrixIn(matrixIn));
   pfmux_far_model far (.clk(clk), .setOut(setOut), .setOe(setOe),
      .setMOut(setMOut), .setMOe(setMOe), .extLevel(extLevel),
      .padOut(padOut), .padOe(padOe), .padIn(padIn), .funcOut(funcOut),
      .funcOe(funcOe), .matrixOut(matrixOut), .matrixOe(matrixOe));
   // ==========================================================
   // 25 MHz clock and a hang guard well above the expected run
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end
   task automatic summarize;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one avalon access; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] b);
      @(posedge clk);
      avsAddress <= a;
      avsWritedata <= d;
      avsByteenable <= b;
      avsRead <= !w;
      avsWrite <= w;
      do @(posedge clk); while (avsWaitrequest !== 1'b0);
      q = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask
   // outputs are registered behind registered peripherals
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // every function on every pad, driving and receiving
   task automatic t_select;
      pfmux_kind_type k;
      for (int p = 0; p < 4; p++) for (int f = 0; f < 6; f++) begin
         bus(1, 8'(4*p), 32'h20 | f, 4'hf);
         @(posedge clk);
         setOut <= ~(24'h1 << (p*6+f));
         setOe <= 24'h1 << (p*6+f);
         settle();
         `CHK({padOut[p], padOe[p]}, 2'b01)
         setOut <= 24'h1 << (p*6+f);
         setOe <= ~(24'h1 << (p*6+f));
         settle();
         `CHK({padOut[p], padOe[p]}, 2'b10)
         for (int l = 0; l < 2; l++) begin
            setOe <= 0;
            extLevel <= l ? 4'hf : 4'h0;
            settle();
            for (int g = 0; g < 6; g++) begin
               k = pfmux_kind_type'(FUNC_KIND[(p*6+g)*2 +: 2]);
               `CHK(funcIn[p*6+g], (g == f || k == KIND_PASS) ? 1'(l) : (k != KIND_FORCE_LO))
            end
         end
      end
   endtask
   // drive codes, and matrix outputs with a partial byte write
   task automatic t_drive_matrix;
      for (int c = 0; c < 4; c++) begin
         bus(1, 8'h04, 32'(c) << 4, 4'hf);
         settle();
         `CHK(padDrive[3:2], 2'(c))
      end
      for (int k = 0; k < 8; k++) begin
         bus(1, 8'h08, (32'(k) << 8) | 32'h26, 4'hf);
         bus(1, 8'h08, (32'(k ^ 1) << 8) | 32'h26, 4'h1);
         bus(0, 8'h08, 0, 4'hf);
         `CHK(q, (32'(k) << 8) | 32'h26)
         @(posedge clk);
         setMOut <= 8'h1 << k;
         setMOe <= ~(8'h1 << k);
         settle();
         `CHK({padOut[2], padOe[2]}, 2'b10)
         setMOut <= ~(8'h1 << k);
         setMOe <= 8'h1 << k;
         settle();
         `CHK({padOut[2], padOe[2]}, 2'b01)
      end
   endtask
   // matrix inputs: default, assigned, inverted, direct route
   task automatic t_matrix_in;
      setMOe <= 0;
      extLevel <= 4'h5;
      for (int p = 0; p < 4; p++) bus(1, 8'(4*p), 32'h26, 4'hf);
      for (int m = 0; m < 8; m++) begin
         bus(1, 8'(32 + 4*m), 0, 4'hf);
         settle();
         `CHK(matrixIn[m], MIN_DEFAULT[m])
         for (int i = 0; i < 2; i++) begin
            bus(1, 8'(32 + 4*m), 32'(m % 4) | 32'h4 | (32'(i) << 3), 4'hf);
            settle();
            `CHK(matrixIn[m], 1'(((m % 4) % 2 == 0) ^ i))
         end
         bus(1, 8'(32 + 4*m), 0, 4'hf);
      end
      bus(1, 8'h00, 32'h20, 4'hf);
      settle();
      `CHK(matrixIn[0], 1'b1)
      bus(0, 8'h40, 0, 4'hf);
      `CHK(q, 32'h5)
      bus(0, 8'h80, 0, 4'hf);
      `CHK(q, 32'h0)
   endtask
   // reset in mid-run kills every driver, then function 1 takes over
   task automatic t_reset;
      setOe <= '1;
      settle();
      `CHK(padOe[0], 1'b1)
      bus(1, 8'h00, 32'h27, 4'hf);
      settle();
      `CHK({padOut[0], padOe[0]}, 2'b00)
      resetn <= 0;
      repeat (2) @(posedge clk);
      `CHK(padOe, 4'h0)
      `CHK(padDrive, 8'haa)
      resetn <= 1;
      settle();
      `CHK(padOe, 4'hf)
      bus(0, 8'h0c, 0, 4'hf);
      `CHK(q, 32'h20)
   endtask
   // ==========================================================
   // main sequence
   initial begin
      resetn <= 0;
      repeat (5) @(posedge clk);
      `CHK(padOe, 4'h0)
      `CHK(matrixIn, 8'h30)
      repeat (5) @(posedge clk);
      resetn <= 1;
      setOe <= 24'h041041;
      settle();
      `CHK(padOe, 4'hf)
      t_select();
      t_drive_matrix();
      t_matrix_in();
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire
